// *** core/vtr_pkg.sv ***
/*
  Shared constants and types for the vector table relocation block:
  register offsets and fields, sequence timing, boot section start
  addresses and vector table offset.
  Assumes word addressed program flash and an APB slave with 32-bit data.
*/
package vtr_pkg;

  // APB byte offsets
  localparam logic [7:0] OFS_GEN_IRQ_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;

  // Control register fields and reset value
  localparam int BIT_UNLOCK = 0;
  localparam int BIT_SELECT = 1;
  localparam int BIT_EXT_LO = 5;
  localparam int BIT_EXT_HI = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WR_MASK = 8'hE3;

  // Status register fields
  localparam int ST_BLOCK = 0;
  localparam int ST_OPEN = 1;
  localparam int ST_HOLD = 2;
  localparam int ST_FUSE_LO = 3;

  // Sequence timing in MCLK cycles
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam logic [2:0] HOLD_CYCLES = 3'h2;
  localparam logic [1:0] FUSE_SETTLE = 2'h3;

  // Word addresses, boot size fuse codes and last vector index
  localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
  localparam logic [15:0] VEC_OFFSET = 16'h0002;
  localparam logic [15:0] BOOT_START_2K = 16'h1C00;
  localparam logic [15:0] BOOT_START_1K = 16'h1E00;
  localparam logic [15:0] BOOT_START_512 = 16'h1F00;
  localparam logic [15:0] BOOT_START_256 = 16'h1F80;
  localparam logic [1:0] SIZE_2K = 2'h0;
  localparam logic [1:0] SIZE_1K = 2'h1;
  localparam logic [1:0] SIZE_512 = 2'h2;
  localparam logic [4:0] LAST_VECTOR = 5'h14;

  // Sequence states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_OPEN = 3'b010,
    SEQ_HOLD = 3'b100
  } seq_e;

  // Fuse and lock bits, raw values: 0 means programmed
  typedef struct packed {
    logic boot_reset_fuse;
    logic [1:0] boot_size_fuses;
    logic app_side_boot_lock;
    logic boot_side_boot_lock;
  } fuse_s;

  // Control register layout
  typedef struct packed {
    logic [2:0] ext_en;
    logic [2:0] rsv;
    logic vector_table_select;
    logic vector_change_unlock;
  } ctrl_s;

endpackage

// *** core/vtr_vec_addr.sv ***
/*
  Registered vector fetch address: table base plus two words per entry.
  Assumes the index comes from logic on MCLK and is at most the last entry.
*/
`timescale 1ns/1ps
`default_nettype none
module vtr_vec_addr (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // Table base and entry
  input wire logic [15:0] base,
  input wire logic [4:0] index,
  // Fetch address
  output logic [15:0] addr
);

  logic [15:0] addr_d;

  // Entries sit two words apart from the table base
  always_comb begin
    addr_d = base + {10'h000, index, 1'b0};
  end

  // Output register keeps the fetch address glitch free
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      addr <= 16'h0000;
    end else begin
      addr <= addr_d;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  property p_entry_step;
    index <= vtr_pkg::LAST_VECTOR |=> addr == $past(base) + 2 * $past(index);
  endproperty
  a_entry_step: assert property (p_entry_step)
    else $error("vector address is not base plus two words per entry");

endmodule
`default_nettype wire

// *** core/vtr_core.sv ***
/*
  Vector table relocation: guarded select of the vector table location,
  automatic interrupt blocking during the change sequence, boot lock
  blocking and reset address choice, with an APB register slave.
  Assumes a zero wait APB master on MCLK, static fuse pins and an
  execution region flag from the core on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module vtr_core (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Fuse and lock pins
  input wire vtr_pkg::fuse_s FUSES,
  // Core side
  input wire logic GLOBAL_IRQ_EN,
  input wire logic EXEC_IN_BOOT,
  input wire logic [4:0] VEC_INDEX,
  output logic IRQ_BLOCK,
  output logic IRQ_ALLOW,
  output logic [2:0] EXT_IRQ_EN,
  output logic [15:0] RESET_ADDR,
  output logic [15:0] VEC_BASE,
  output logic [15:0] VECTOR_ADDR
);

  vtr_pkg::fuse_s fuse_m_q;
  vtr_pkg::fuse_s fuse_s_q;
  vtr_pkg::fuse_s fuse_q;
  logic [1:0] settle_q;
  vtr_pkg::ctrl_s ctrl_q;
  vtr_pkg::seq_e seq_q;
  vtr_pkg::seq_e seq_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic sel_d;
  logic [31:0] rdata_q;
  logic [7:0] status;
  logic hit_ctrl;
  logic hit_status;
  logic ctrl_wr;
  logic unlock_wr;
  logic select_wr;
  logic lock_block;
  logic [15:0] boot_start;
  logic [15:0] reset_addr_d;
  logic [15:0] vec_base_d;

  // Fuse pins are asynchronous to MCLK, so pass two flip-flops first
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fuse_m_q <= '1;
      fuse_s_q <= '1;
    end else begin
      fuse_m_q <= FUSES;
      fuse_s_q <= fuse_m_q;
    end
  end

  // Fuses caught once after release; later pin changes have no effect
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      settle_q <= 2'h0;
      fuse_q <= '1;
    end else if (settle_q != vtr_pkg::FUSE_SETTLE) begin
      settle_q <= settle_q + 2'h1;
      fuse_q <= fuse_s_q;
    end
  end

  // Address decode; the master holds the request through the access phase
  assign hit_ctrl = (PADDR == vtr_pkg::OFS_GEN_IRQ_CTRL);
  assign hit_status = (PADDR == vtr_pkg::OFS_STATUS);
  assign ctrl_wr = PSEL && PENABLE && PWRITE && hit_ctrl;
  assign unlock_wr = ctrl_wr && PWDATA[vtr_pkg::BIT_UNLOCK];
  assign select_wr = ctrl_wr && !PWDATA[vtr_pkg::BIT_UNLOCK]
    && (seq_q == vtr_pkg::SEQ_OPEN);

  // Zero wait slave; unmapped addresses answer with an error
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !(hit_ctrl || hit_status);
  assign PRDATA = rdata_q;

  // Status byte shows sequence state and the caught fuse bits
  always_comb begin
    status = 8'h00;
    status[vtr_pkg::ST_BLOCK] = IRQ_BLOCK;
    status[vtr_pkg::ST_OPEN] = (seq_q == vtr_pkg::SEQ_OPEN);
    status[vtr_pkg::ST_HOLD] = (seq_q == vtr_pkg::SEQ_HOLD);
    status[7:vtr_pkg::ST_FUSE_LO] = fuse_q;
  end

  // Read data registered in the setup cycle, ready for the access phase
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      if (hit_ctrl) begin
        rdata_q <= {24'h000000, ctrl_q};
      end else if (hit_status) begin
        rdata_q <= {24'h000000, status};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  // Change sequence: unlock opens a window, a select write ends it
  always_comb begin
    seq_d = seq_q;
    cnt_d = cnt_q;
    sel_d = ctrl_q.vector_table_select;
    unique case (seq_q)
      vtr_pkg::SEQ_IDLE, vtr_pkg::SEQ_HOLD: begin
        if (unlock_wr) begin
          seq_d = vtr_pkg::SEQ_OPEN;
          cnt_d = vtr_pkg::UNLOCK_CYCLES - 3'h1;
        end else if (seq_q == vtr_pkg::SEQ_HOLD) begin
          if (cnt_q == 3'h0) begin
            seq_d = vtr_pkg::SEQ_IDLE;
          end else begin
            cnt_d = cnt_q - 3'h1;
          end
        end
      end
      vtr_pkg::SEQ_OPEN: begin
        if (select_wr) begin
          // Hold on until the following instruction is done
          sel_d = PWDATA[vtr_pkg::BIT_SELECT];
          seq_d = vtr_pkg::SEQ_HOLD;
          cnt_d = vtr_pkg::HOLD_CYCLES - 3'h1;
        end else if (unlock_wr) begin
          cnt_d = vtr_pkg::UNLOCK_CYCLES - 3'h1;
        end else if (cnt_q == 3'h0) begin
          seq_d = vtr_pkg::SEQ_IDLE;
        end else begin
          cnt_d = cnt_q - 3'h1;
        end
      end
      default: begin
        seq_d = vtr_pkg::SEQ_IDLE;
        cnt_d = 3'h0;
      end
    endcase
  end

  // Sequence state and its cycle counter
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      seq_q <= vtr_pkg::SEQ_IDLE;
      cnt_q <= 3'h0;
    end else begin
      seq_q <= seq_d;
      cnt_q <= cnt_d;
    end
  end

  // Control register; the unlock bit mirrors the open window
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_q <= vtr_pkg::CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_q.ext_en <= PWDATA[vtr_pkg::BIT_EXT_HI:vtr_pkg::BIT_EXT_LO];
      end
      ctrl_q.rsv <= 3'h0;
      ctrl_q.vector_table_select <= sel_d;
      ctrl_q.vector_change_unlock <= (seq_d == vtr_pkg::SEQ_OPEN);
    end
  end

  // Lock bits block interrupts when code runs outside the table's section
  assign lock_block =
    (ctrl_q.vector_table_select && !fuse_q.app_side_boot_lock
     && !EXEC_IN_BOOT)
    || (!ctrl_q.vector_table_select && !fuse_q.boot_side_boot_lock
     && EXEC_IN_BOOT);

  // Blocking starts in the very cycle of the unlock write
  assign IRQ_BLOCK = unlock_wr || (seq_q != vtr_pkg::SEQ_IDLE)
    || lock_block;
  // Global flag is only gated here, never written back
  assign IRQ_ALLOW = GLOBAL_IRQ_EN && !IRQ_BLOCK;
  assign EXT_IRQ_EN = ctrl_q.ext_en;

  // Boot section start from the size fuses
  always_comb begin
    unique case (fuse_q.boot_size_fuses)
      vtr_pkg::SIZE_2K: boot_start = vtr_pkg::BOOT_START_2K;
      vtr_pkg::SIZE_1K: boot_start = vtr_pkg::BOOT_START_1K;
      vtr_pkg::SIZE_512: boot_start = vtr_pkg::BOOT_START_512;
      default: boot_start = vtr_pkg::BOOT_START_256;
    endcase
  end

  // Reset and table base choice
  always_comb begin
    reset_addr_d = fuse_q.boot_reset_fuse ? vtr_pkg::APP_RESET_ADDR
      : boot_start;
    vec_base_d = (ctrl_q.vector_table_select ? boot_start
      : vtr_pkg::APP_RESET_ADDR) + vtr_pkg::VEC_OFFSET;
  end

  // Address outputs registered
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RESET_ADDR <= vtr_pkg::APP_RESET_ADDR;
      VEC_BASE <= vtr_pkg::VEC_OFFSET;
    end else begin
      RESET_ADDR <= reset_addr_d;
      VEC_BASE <= vec_base_d;
    end
  end

  // Entry address for the vector being taken
  vtr_vec_addr u_vec_addr (
    .MCLK(MCLK),
    .RESET_N(RESET_N),
    .base(VEC_BASE),
    .index(VEC_INDEX),
    .addr(VECTOR_ADDR)
  );

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  property p_unlock_opens;
    unlock_wr |=> ctrl_q.vector_change_unlock && IRQ_BLOCK;
  endproperty
  a_unlock_opens: assert property (p_unlock_opens)
    else $error("unlock write did not open the window");

  property p_block_now;
    unlock_wr |-> IRQ_BLOCK && !IRQ_ALLOW;
  endproperty
  a_block_now: assert property (p_block_now)
    else $error("interrupts not blocked in the unlock cycle");

  property p_window_ends;
    (ctrl_q.vector_change_unlock && !ctrl_wr) [*4]
      |=> !ctrl_q.vector_change_unlock;
  endproperty
  a_window_ends: assert property (p_window_ends)
    else $error("unlock bit outlived four cycles");

  property p_select_clears;
    select_wr |=> !ctrl_q.vector_change_unlock
      && ctrl_q.vector_table_select == $past(PWDATA[1]);
  endproperty
  a_select_clears: assert property (p_select_clears)
    else $error("select write did not land or unlock stayed set");

  property p_select_guard;
    $changed(ctrl_q.vector_table_select) |-> $past(select_wr);
  endproperty
  a_select_guard: assert property (p_select_guard)
    else $error("vector select changed outside the window");

  property p_timeout_release;
    $fell(ctrl_q.vector_change_unlock) && !$past(ctrl_wr) && !lock_block
      && !ctrl_wr |-> !IRQ_BLOCK;
  endproperty
  a_timeout_release: assert property (p_timeout_release)
    else $error("blocking did not end after the window");

  property p_lock_app;
    ctrl_q.vector_table_select && !fuse_q.app_side_boot_lock
      && !EXEC_IN_BOOT |-> IRQ_BLOCK;
  endproperty
  a_lock_app: assert property (p_lock_app)
    else $error("application code not blocked under boot table");

  property p_lock_boot;
    !ctrl_q.vector_table_select && !fuse_q.boot_side_boot_lock
      && EXEC_IN_BOOT |-> IRQ_BLOCK;
  endproperty
  a_lock_boot: assert property (p_lock_boot)
    else $error("boot code not blocked under application table");

  property p_base;
    ##1 VEC_BASE == ($past(ctrl_q.vector_table_select)
      ? $past(boot_start) + 16'h0002 : 16'h0002);
  endproperty
  a_base: assert property (p_base)
    else $error("vector base does not follow select");

  property p_reset_2k;
    !fuse_q.boot_reset_fuse && fuse_q.boot_size_fuses == 2'h0
      |=> RESET_ADDR == 16'h1C00;
  endproperty
  a_reset_2k: assert property (p_reset_2k)
    else $error("reset address wrong for 2K boot section");

  property p_reserved;
    PSEL && PENABLE && !PWRITE && hit_ctrl |-> PRDATA[4:2] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control bits not zero");

  c_move: cover property (unlock_wr ##[1:4] select_wr);
  c_timeout: cover property (unlock_wr ##1 (!ctrl_wr) [*4]);
  c_boot_table: cover property (ctrl_q.vector_table_select);
  c_lock: cover property (lock_block && GLOBAL_IRQ_EN);

endmodule
`default_nettype wire

// *** tb/vtr_cpu_model.sv ***
/*
  Processor side model: issues APB register transfers to the block.
  Assumes a slave on MCLK; the caller may chain transfers back to back.
*/
`timescale 1ns/1ps
`default_nettype none
module vtr_cpu_model (
  // Clock
  input wire logic MCLK,
  // APB master
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [7:0] PADDR,
  output logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  bit held;

  // Idle bus at time zero
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    held = 1'b0;
  end

  // One transfer; more keeps select up so the next setup follows at once
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input bit more,
                      output logic [31:0] q, output logic e);
    if (!held) begin
      @(posedge MCLK);
      PSEL <= 1'b1;
    end
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PENABLE <= 1'b0;
    held = more;
    if (!more) begin
      // Released data must not look valid
      PSEL <= 1'b0;
      PWDATA <= ~d;
    end
  endtask
endmodule
`default_nettype wire

// *** tb/tb_vector_table_relocation.sv ***
/*
  Self-checking bench for the vector table relocation block.
  Assumes the cpu model drives APB and the bench drives core and fuse pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_vector_table_relocation;
  localparam logic [7:0] CTL = vtr_pkg::OFS_GEN_IRQ_CTRL;
  localparam logic [7:0] STA = vtr_pkg::OFS_STATUS;
  logic MCLK, RESET_N, GLOBAL_IRQ_EN, EXEC_IN_BOOT;
  logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ_BLOCK, IRQ_ALLOW;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  logic [4:0] VEC_INDEX;
  logic [2:0] EXT_IRQ_EN;
  logic [15:0] RESET_ADDR, VEC_BASE, VECTOR_ADDR;
  logic [15:0] starts [4];
  vtr_pkg::fuse_s FUSES;
  logic e;
  int mismatches, cmp_count;

  `define CHK(n, x, g) begin cmp_count++; if ((g) !== (x)) begin \
    mismatches++; $display("BAD %s exp %h got %h", n, x, g); end end

  vtr_cpu_model cpu (.MCLK(MCLK), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR));

  vtr_core dut (.MCLK(MCLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FUSES(FUSES),
    .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .EXEC_IN_BOOT(EXEC_IN_BOOT),
    .VEC_INDEX(VEC_INDEX), .IRQ_BLOCK(IRQ_BLOCK), .IRQ_ALLOW(IRQ_ALLOW),
    .EXT_IRQ_EN(EXT_IRQ_EN), .RESET_ADDR(RESET_ADDR),
    .VEC_BASE(VEC_BASE), .VECTOR_ADDR(VECTOR_ADDR));

  // 200 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input bit more = 1'b0);
    cpu.xfer(1'b1, a, {24'h000000, d}, more, q, e);
  endtask

  // More keeps select up so a chained transfer follows at once
  task automatic rd(input logic [7:0] a, input bit more = 1'b0);
    cpu.xfer(1'b0, a, 32'h0000_0000, more, q, e);
  endtask

  // Sample a little after the edge so register updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  // Fuses are caught once after release, so each setting needs a reset
  task automatic rst(input vtr_pkg::fuse_s f);
    @(posedge MCLK);
    RESET_N <= 1'b0;
    FUSES <= f;
    repeat (2) @(posedge MCLK);
    RESET_N <= 1'b1;
    step(8);
  endtask

  // Unlock then select write in the very next transfer
  task automatic move(input logic [7:0] d);
    wr(CTL, 8'hE1, 1'b1);
    wr(CTL, d);
  endtask

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end

  initial begin
    RESET_N = 1'b0;
    FUSES = 5'h13;
    GLOBAL_IRQ_EN = 1'b1;
    EXEC_IN_BOOT = 1'b0;
    VEC_INDEX = 5'h00;
    starts = '{vtr_pkg::BOOT_START_2K, vtr_pkg::BOOT_START_1K,
               vtr_pkg::BOOT_START_512, vtr_pkg::BOOT_START_256};
    // 2K boot section, reset fuse and both locks unprogrammed
    rst(5'h13);
    rd(CTL);
    `CHK("ctrl", 8'h00, q[7:0])
    `CHK("ctrl_err", 1'b0, e)
    `CHK("reset_addr", 16'h0000, RESET_ADDR)
    `CHK("vec_base", 16'h0002, VEC_BASE)
    wr(CTL, 8'hFE);
    rd(CTL);
    `CHK("ctrl", 8'hE0, q[7:0])
    `CHK("ext_en", 3'h7, EXT_IRQ_EN)
    wr(STA, 8'h00);
    rd(STA);
    `CHK("status", 8'h98, q[7:0])
    rd(8'h08);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_data", 32'h0, q)
    $display("Test reset_and_map done");
    // Relocation back to back
    `CHK("allow", 1'b1, IRQ_ALLOW)
    @(posedge MCLK);
    GLOBAL_IRQ_EN <= 1'b0;
    step(1);
    `CHK("allow", 1'b0, IRQ_ALLOW)
    @(posedge MCLK);
    GLOBAL_IRQ_EN <= 1'b1;
    step(1);
    move(8'hE2);
    step(1);
    `CHK("block", 1'b1, IRQ_BLOCK)
    `CHK("allow", 1'b0, IRQ_ALLOW)
    step(2);
    `CHK("block", 1'b0, IRQ_BLOCK)
    `CHK("allow", 1'b1, IRQ_ALLOW)
    rd(CTL);
    `CHK("ctrl", 8'hE2, q[7:0])
    `CHK("vec_base", 16'h1C02, VEC_BASE)
    for (int i = 0; i < 20; i++) begin
      @(posedge MCLK);
      VEC_INDEX <= i[4:0];
      step(1);
      `CHK("vec_addr", 16'h1C02 + 16'(2 * i), VECTOR_ADDR)
    end
    $display("Test relocate done");
    // Chained read between, so the select write lands on the fourth edge
    wr(CTL, 8'hE1, 1'b1);
    rd(CTL, 1'b1);
    `CHK("ctrl", 8'hE3, q[7:0])
    wr(CTL, 8'hE0);
    rd(CTL);
    `CHK("ctrl", 8'hE0, q[7:0])
    `CHK("vec_base", 16'h0002, VEC_BASE)
    // Unlock alone: blocking ends after four cycles
    wr(CTL, 8'hE1);
    step(3);
    `CHK("block", 1'b1, IRQ_BLOCK)
    step(1);
    `CHK("block", 1'b0, IRQ_BLOCK)
    // Idle cycle plus chained read puts the select write on edge five
    wr(CTL, 8'hE1);
    rd(STA, 1'b1);
    `CHK("status", 8'h9B, q[7:0])
    wr(CTL, 8'hE2);
    rd(CTL);
    `CHK("ctrl", 8'hE0, q[7:0])
    $display("Test window done");
    // Lock bits
    rst({1'b1, 2'b00, 1'b0, 1'b1});
    move(8'hE2);
    step(4);
    `CHK("block", 1'b1, IRQ_BLOCK)
    @(posedge MCLK);
    EXEC_IN_BOOT <= 1'b1;
    step(1);
    `CHK("block", 1'b0, IRQ_BLOCK)
    rst({1'b1, 2'b00, 1'b1, 1'b0});
    `CHK("block", 1'b1, IRQ_BLOCK)
    move(8'hE2);
    step(4);
    `CHK("block", 1'b0, IRQ_BLOCK)
    @(posedge MCLK);
    EXEC_IN_BOOT <= 1'b0;
    $display("Test locks done");
    // Boot size and reset fuse
    for (int s = 0; s < 4; s++) begin
      rst({1'b0, s[1:0], 2'b11});
      `CHK("reset_addr", starts[s], RESET_ADDR)
      move(8'hE2);
      step(4);
      `CHK("vec_base", starts[s] + 16'h0002, VEC_BASE)
    end
    $display("Test fuses done");
    finish_test();
  end
endmodule
`default_nettype wire
